//--- logic/limit_switch_defines.svh
// Offsets, field positions, reset values and timing counts of the limit switch.
`ifndef LIMIT_SWITCH_DEFINES_SVH
`define LIMIT_SWITCH_DEFINES_SVH

`define LS_OFF_CTRL      12'h000
`define LS_OFF_ON_VAL    12'h004
`define LS_OFF_OFF_VAL   12'h008
`define LS_OFF_ON_DLY    12'h00C
`define LS_OFF_OFF_DLY   12'h010
`define LS_OFF_STATUS    12'h014

`define LS_CTRL_FUNC_LSB 0
`define LS_CTRL_FAIL_LSB 4
`define LS_CTRL_INV_BIT  6

`define LS_CTRL_RESET    32'h0000_0010
`define LS_VAL_RESET     32'h0000_0000
`define LS_DLY_RESET     32'h0000_0000

`define LS_CLK_MHZ       125
`define LS_TICK_NS       100000000
`define LS_TICK_CYCLES   ((`LS_TICK_NS / 1000) * `LS_CLK_MHZ)
`define LS_DLY_MAX_TICKS 16'd1000

`endif

//--- logic/limit_switch_pkg.sv
// Types shared by the limit switch design.
package limit_switch_pkg;

  typedef enum logic [2:0] {
    FUNC_OFF,
    FUNC_ON,
    FUNC_DIAG,
    FUNC_LIMIT,
    FUNC_DIGITAL
  } func_e;

  typedef enum logic [1:0] {
    FAIL_ACTUAL,
    FAIL_OPEN,
    FAIL_CLOSED
  } fail_e;

endpackage : limit_switch_pkg

//--- logic/limit_switch_hysteresis.sv
// Limit switch output with hysteresis, delays, failure state and APB access.
`timescale 1ns/1ps
`include "limit_switch_defines.svh"

module limit_switch_hysteresis #(
  parameter int TICK_CYCLES = `LS_TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] process_value,
  input  wire logic        process_valid,
  input  wire logic        error_in,
  input  wire logic        diag_event,
  input  wire logic        digital_in,
  output logic             switch_closed
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [2:0]         func_r;
  logic [1:0]         fail_r;
  logic               inv_r;

  logic signed [31:0] on_val_r;
  logic signed [31:0] off_val_r;

  logic [15:0]        on_dly_r;
  logic [15:0]        off_dly_r;

  logic               state_r;
  logic               wr_en;
  logic               rd_en;
  logic               addr_ok;
  logic [31:0]        rd_word;

  // Synchronised pin levels; only error_s is also read back by the status word.
  logic               error_s;
  logic               diag_s;
  logic               dig_s;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [15:0] clip_dly(input logic [31:0] d);
    // Values past 100 s saturate rather than wrap, so a typo errs long.
    if (d[31:16] != 16'h0000 || d[15:0] > `LS_DLY_MAX_TICKS) begin
      return `LS_DLY_MAX_TICKS;
    end
    return d[15:0];
  endfunction : clip_dly

  // An illegal function code falls back to Off, which opens the switch unless inversion is set.
  function automatic logic [2:0] clip_func(input logic [2:0] f);
    if (f > 3'(limit_switch_pkg::FUNC_DIGITAL)) begin
      return 3'(limit_switch_pkg::FUNC_OFF);
    end
    return f;
  endfunction : clip_func

  // The unused failure code reads as open, the factory failure state.
  function automatic logic [1:0] clip_fail(input logic [1:0] f);
    if (f > 2'(limit_switch_pkg::FAIL_CLOSED)) begin
      return 2'(limit_switch_pkg::FAIL_OPEN);
    end
    return f;
  endfunction : clip_fail

  function automatic logic is_func(input logic [2:0] f,
                                   input logic [2:0] m);
    return f == m;
  endfunction : is_func

  // One strict comparison serves all four threshold rules.
  function automatic logic past(input logic signed [31:0] v,
                                input logic signed [31:0] thr,
                                input logic               above);
    if (above) begin
      return v > thr;
    end
    return v < thr;
  endfunction : past

  // A zero delay lets the first edge that sees the condition switch.
  function automatic logic delay_done(input logic [15:0] cnt,
                                      input logic [15:0] lim);
    return cnt >= lim;
  endfunction : delay_done

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Status is mapped for reads; a write to it is simply dropped.
  always_comb begin
    case (paddr)
      `LS_OFF_CTRL, `LS_OFF_ON_VAL, `LS_OFF_OFF_VAL,
      `LS_OFF_ON_DLY, `LS_OFF_OFF_DLY, `LS_OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & penable & ~pwrite;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Reset fields are cut from the one reset word, so both stay in step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_r <= 3'(`LS_CTRL_RESET >> `LS_CTRL_FUNC_LSB);
      fail_r <= 2'(`LS_CTRL_RESET >> `LS_CTRL_FAIL_LSB);
      inv_r  <= 1'(`LS_CTRL_RESET >> `LS_CTRL_INV_BIT);
    end else if (wr_en && paddr == `LS_OFF_CTRL) begin
      func_r <= clip_func(pwdata[`LS_CTRL_FUNC_LSB +: 3]);
      fail_r <= clip_fail(pwdata[`LS_CTRL_FAIL_LSB +: 2]);
      inv_r  <= pwdata[`LS_CTRL_INV_BIT];
    end
  end

  // ****************************************************************
  // Threshold registers
  // ****************************************************************
  // Thresholds are signed; equal values act as on below off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_val_r <= `LS_VAL_RESET;
    end else if (wr_en && paddr == `LS_OFF_ON_VAL) begin
      on_val_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_val_r <= `LS_VAL_RESET;
    end else if (wr_en && paddr == `LS_OFF_OFF_VAL) begin
      off_val_r <= pwdata;
    end
  end

  // ****************************************************************
  // Delay registers
  // ****************************************************************
  // Counts are in delay ticks; writes past the ceiling saturate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_dly_r <= 16'(`LS_DLY_RESET);
    end else if (wr_en && paddr == `LS_OFF_ON_DLY) begin
      on_dly_r <= clip_dly(pwdata);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_dly_r <= 16'(`LS_DLY_RESET);
    end else if (wr_en && paddr == `LS_OFF_OFF_DLY) begin
      off_dly_r <= clip_dly(pwdata);
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // Unmapped words read as zero, flagged by pslverr.
  always_comb begin
    case (paddr)
      `LS_OFF_CTRL:    rd_word = {25'h0, inv_r, fail_r, 1'b0, func_r};
      `LS_OFF_ON_VAL:  rd_word = on_val_r;
      `LS_OFF_OFF_VAL: rd_word = off_val_r;
      `LS_OFF_ON_DLY:  rd_word = {16'h0, on_dly_r};
      `LS_OFF_OFF_DLY: rd_word = {16'h0, off_dly_r};
      `LS_OFF_STATUS:  rd_word = {29'h0, error_s, state_r, switch_closed};
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic err_meta_r;
  logic err_sync_r;
  logic diag_meta_r;
  logic diag_sync_r;
  logic dig_meta_r;
  logic dig_sync_r;

  // Each pin has its own flop pair; only the second flop is read.
  // This costs two cycles of latency on every pin-driven decision.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_meta_r <= 1'b0;
      err_sync_r <= 1'b0;
    end else begin
      err_meta_r <= error_in;
      err_sync_r <= err_meta_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_meta_r <= 1'b0;
      diag_sync_r <= 1'b0;
    end else begin
      diag_meta_r <= diag_event;
      diag_sync_r <= diag_meta_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_meta_r <= 1'b0;
      dig_sync_r <= 1'b0;
    end else begin
      dig_meta_r <= digital_in;
      dig_sync_r <= dig_meta_r;
    end
  end

  assign error_s = err_sync_r;
  assign diag_s  = diag_sync_r;
  assign dig_s   = dig_sync_r;

  // ****************************************************************
  // Limit comparison and delays
  // ****************************************************************
  // The process value comes from same-clock measurement logic and is
  // sampled only while process_valid is high.
  logic        want_close;
  logic        want_open;
  logic        on_above;
  logic [26:0] tick_cnt_r;
  logic        tick;
  logic [15:0] dly_cnt_r;
  logic        pending;

  assign on_above = on_val_r > off_val_r;

  always_comb begin
    want_close = 1'b0;
    want_open  = 1'b0;
    if (process_valid) begin
      if (on_above) begin
        want_close = past(process_value, on_val_r, 1'b1);
        want_open  = past(process_value, off_val_r, 1'b0);
      end else begin
        want_close = past(process_value, on_val_r, 1'b0);
        want_open  = past(process_value, off_val_r, 1'b1);
      end
    end
  end
  // Equal thresholds leave at most one condition true; neither means hold.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 27'h0;
    end else if (tick_cnt_r == 27'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 27'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 27'h1;
    end
  end

  assign tick = tick_cnt_r == 27'(TICK_CYCLES - 1);

  // A closing request while closed, or opening while open, is no change.
  assign pending = state_r ? want_open : want_close;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_r <= 16'h0;
    end else if (!pending ||
                 !is_func(func_r, 3'(limit_switch_pkg::FUNC_LIMIT))) begin
      dly_cnt_r <= 16'h0;
    end else begin
      if (tick) begin
        dly_cnt_r <= dly_cnt_r + 16'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= 1'b1;
    end else if (pending && want_close && delay_done(dly_cnt_r, on_dly_r)) begin
      state_r <= 1'b1;
    end else if (pending && want_open && delay_done(dly_cnt_r, off_dly_r)) begin
      state_r <= 1'b0;
    end else begin
      state_r <= state_r;
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  logic base_q;
  logic out_nxt;

  always_comb begin
    case (func_r)
      3'(limit_switch_pkg::FUNC_ON):      base_q = 1'b1;
      3'(limit_switch_pkg::FUNC_DIAG):    base_q = ~diag_s;
      3'(limit_switch_pkg::FUNC_LIMIT):   base_q = state_r;
      3'(limit_switch_pkg::FUNC_DIGITAL): base_q = dig_s;
      default:                            base_q = 1'b0;
    endcase
    out_nxt = base_q ^ inv_r;
    if (error_s &&
        (is_func(func_r, 3'(limit_switch_pkg::FUNC_LIMIT)) ||
         is_func(func_r, 3'(limit_switch_pkg::FUNC_DIGITAL)))) begin
      case (fail_r)
        2'(limit_switch_pkg::FAIL_OPEN):   out_nxt = 1'b0;
        2'(limit_switch_pkg::FAIL_CLOSED): out_nxt = 1'b1;
        default:                           out_nxt = switch_closed;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_closed <= 1'b0;
    end else begin
      switch_closed <= out_nxt;
    end
  end

endmodule : limit_switch_hysteresis

//--- testbench/load_model.sv
// Far-side load that senses the switch contact.
`timescale 1ns/1ps
module load_model (
  input  wire logic pclk,
  input  wire logic switch_closed,
  output logic      load_on
);
  // The load sees the contact one clock late, as a real input stage would.
  always_ff @(posedge pclk) begin
    load_on <= switch_closed;
  end
endmodule : load_model

//--- testbench/ls_chk.sv
// Checker for the limit switch output.
`timescale 1ns/1ps
module ls_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] process_value,
  input wire logic        process_valid,
  input wire logic        error_in,
  input wire logic        switch_closed
);
  logic [31:0] rg [0:4];
  wire signed [31:0] on_v = rg[1];
  wire signed [31:0] off_v = rg[2];
  wire signed [31:0] pv = process_value;
  wire lim = rg[0][2:0] == 3'h3 && !error_in && process_valid
    && rg[3] == 32'h0 && rg[4] == 32'h0;
  wire up = on_v > off_v;
  wire plain = lim && !rg[0][6];
  wire cls = up ? pv > on_v : pv < on_v;
  wire opn = up ? pv < off_v : pv > off_v;
  // Shadow of the settings, so the checker needs no internal probes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rg[0] <= 32'h10;
      for (int i = 1; i < 5; i++) rg[i] <= 32'h0;
    end else if (psel && penable && pwrite && paddr < 12'h014) begin
      rg[paddr[4:2]] <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_close_above: assert property (
    (plain && up && pv > on_v) [*5] |-> switch_closed)
    else $error("no close above on value");
  a_open_below: assert property (
    (plain && up && pv < off_v) [*5] |-> !switch_closed)
    else $error("no open below off value");
  a_close_low: assert property (
    (plain && !up && pv < on_v) [*5] |-> switch_closed)
    else $error("no close below on value");
  a_open_high: assert property (
    (plain && !up && pv > off_v) [*5] |-> !switch_closed)
    else $error("no open above off value");
  a_fail_open: assert property (
    (rg[0][5:0] == 6'h13 && error_in) [*5] |-> !switch_closed)
    else $error("failure open not applied");
  a_fail_closed: assert property (
    (rg[0][5:0] == 6'h23 && error_in) [*5] |-> switch_closed)
    else $error("failure closed not applied");
  a_invert_swap: assert property (
    (lim && rg[0][6] && cls) [*5] |-> !switch_closed)
    else $error("inversion not applied");
  a_hold_between: assert property (
    (plain && !cls && !opn) [*5] |-> $stable(switch_closed))
    else $error("output moved between limits");
endmodule : ls_chk
bind limit_switch_hysteresis ls_chk ls_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .process_value(process_value),
  .process_valid(process_valid), .error_in(error_in),
  .switch_closed(switch_closed));

//--- testbench/testbench.sv
// Self-checking bench for the limit switch.
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        error_in = 0, diag_event = 0, digital_in = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, process_value = 32'h0, got;
  logic [32:0] q[$], n;
  wire  [31:0] prdata;
  wire         pready, pslverr, switch_closed, load_on;
  int          mismatches = 0, checks_done = 0, cyc = 0;
  limit_switch_hysteresis #(.TICK_CYCLES(4)) limit_switch_hysteresis_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .process_value(process_value),
    .process_valid(1'b1), .error_in(error_in), .diag_event(diag_event),
    .digital_in(digital_in), .switch_closed(switch_closed));
  load_model load_model_i (.pclk(pclk), .switch_closed(switch_closed),
    .load_on(load_on));
  always #4 pclk = ~pclk;
  task wrap_up;
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // A hang is cut short here rather than left to the simulator.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  // Only words up to the status word are mapped.
  always @(posedge pclk) begin
    if (psel && penable) begin
      checks_done++;
      if (pslverr !== (paddr > 12'h014)) begin
        mismatches++;
        $display("[FAIL] pslverr exp %b got %b", paddr > 12'h014, pslverr);
      end
    end
  end
  always @(negedge pclk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      got = n[32] ? prdata : {31'h0, switch_closed};
      checks_done++;
      if (got !== n[31:0]) begin
        mismatches++;
        $display("[FAIL] %s exp %h got %h", n[32] ? "prdata" : "switch",
          n[31:0], got);
      end
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    q.push_back({1'b1, e});
  endtask : rd
  task hold(input int c, input logic e);
    repeat (c) @(posedge pclk);
    q.push_back({32'h0, e});
  endtask : hold
  task set(input logic [31:0] v, input logic e);
    process_value <= v;
    hold(6, e);
  endtask : set
  initial begin
    void'($urandom(48740));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h10);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h018, 32'h0);
    apb(1'b1, 12'h004, 32'h64);
    apb(1'b1, 12'h008, 32'h32);
    apb(1'b1, 12'h000, 32'h13);
    set(32'h65 + $urandom % 32'h30, 1'b1);
    set(32'h4B, 1'b1);
    set(32'h31 - $urandom % 32'h30, 1'b0);
    set(32'h4B, 1'b0);
    apb(1'b1, 12'h004, 32'hFFFF_FFEC);
    apb(1'b1, 12'h008, 32'h1E);
    set(32'h0, 1'b0);
    set(32'hFFFF_FFEB - $urandom % 32'h30, 1'b1);
    set(32'h1F + $urandom % 32'h30, 1'b0);
    set(32'hFFFF_FFCE, 1'b1);
    apb(1'b1, 12'h000, 32'h53);
    set(32'hFFFF_FFCE, 1'b0);
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, 12'h000, 32'h3 | (f << 4));
      error_in <= 1'b1;
      // The error needs its sync delay before the value may move.
      repeat (4) @(posedge pclk);
      set(32'h1F, f != 1);
      error_in <= 1'b0;
      set(32'hFFFF_FFCE, 1'b1);
    end
    apb(1'b1, 12'h000, 32'h20);
    error_in <= 1'b1;
    set(32'hFFFF_FFCE, 1'b0);
    error_in <= 1'b0;
    apb(1'b1, 12'h000, 32'h14);
    digital_in <= 1'b1;
    hold(6, 1'b1);
    error_in <= 1'b1;
    hold(6, 1'b0);
    error_in <= 1'b0;
    digital_in <= 1'b0;
    hold(6, 1'b0);
    apb(1'b1, 12'h000, 32'h02);
    hold(6, 1'b1);
    error_in <= 1'b1;
    hold(6, 1'b1);
    error_in <= 1'b0;
    diag_event <= 1'b1;
    hold(6, 1'b0);
    diag_event <= 1'b0;
    apb(1'b1, 12'h000, 32'h13);
    set(32'hFFFF_FFCE, 1'b1);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h010, 32'h3);
    set(32'h1F, 1'b1);
    hold(10, 1'b0);
    set(32'hFFFF_FFCE, 1'b0);
    set(32'h0, 1'b0);
    set(32'hFFFF_FFCE, 1'b0);
    hold(12, 1'b1);
    rd(12'h014, 32'h3);
    @(posedge pclk);
    wrap_up;
  end
endmodule : testbench
